// >>> hw/sc_top.sv
// Serial configuration loader and operating-mode sequencer.
// Pins are sampled as synchronous to core_clk; serial clock far slower.
//
// Overview of operation
// - Bit 31 high selects clock-only mode, low normal transmit.
// - Bit 30 selects upper or lower oscillator band.
// - Bits 29..15 form the 15-bit carrier step word, MSB first.
// - Bits 14..7 form the 8-bit FSK deviation word.
// - Bit 6 selects clock output divide by four or by eight.
// - Bits 5..2 form the 4-bit power amplifier level code.
// - Bit 1 selects amplitude keying, else frequency keying.
// - Bit 0 turns the clock output driver on.
// - Word is sent serially, most significant bit first.
// - Data is sampled on each serial clock rising edge.
// - Word is applied on falling edge after the final bit.
// - After 32 bits the data line becomes modulation input.
// - Further serial clock edges are ignored until restart.
// - Off state stops crystal oscillator and synthesizer.
// - Register reset keeps crystal on, synthesizer and amplifier off.
// - Clock driver runs only when the clock-on bit is set.
// - Transitions depend on pin conditions, the word load and the reset hold count.
module sc_top
   import sc_pkg::*;
(
   // Clock and reset
   input  wire logic    core_clk,
   input  wire logic    sys_rst,
   // Host pins
   input  wire logic    enable_line,
   input  wire logic    shared_data_modulation_line,
   input  wire logic    serial_clock,
   // Applied configuration
   output sc_cfg_t      active_cfg,
   // Circuit activity
   output sc_blocks_t   blocks,
   output sc_mode_t     mode,
   output logic         clock_divide_by_four
);

   // ==========================================================
   // State
   typedef struct packed {
      sc_mode_t          mode;
      sc_cfg_t           cfg;
      logic              cfg_valid;
      logic              sck_q;
      logic [CNT_W-1:0]  low_cnt;
      sc_blocks_t        blocks;
   } sc_state_t;

   sc_state_t st;
   sc_state_t next_st;

   logic             rise;
   logic             fall;
   logic             restart;
   logic             load;
   logic [31:0]      word;
   sc_cfg_t          new_cfg;

   assign rise = serial_clock && !st.sck_q;
   assign fall = !serial_clock && st.sck_q;
   // Any stay with enable low clears the bit count
   assign restart = !enable_line;

   sc_shift u_shift (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .restart  (restart),
      .rise     (rise),
      .fall     (fall),
      .data_in  (shared_data_modulation_line),
      .load     (load),
      .word     (word),
      .done     ()
   );

   // ==========================================================
   // Field decode
   always_comb
   begin
      new_cfg.clock_only           = word[BIT_CLK_ONLY];
      new_cfg.vco_band_select      = word[BIT_BAND];
      new_cfg.carrier_step_word    = word[STEP_MSB:STEP_LSB];
      new_cfg.fsk_deviation_word   = word[DEV_MSB:DEV_LSB];
      new_cfg.clock_divider_select = word[BIT_DIV];
      new_cfg.pa_level_code        = word[PA_MSB:PA_LSB];
      new_cfg.keying_type_select   = word[BIT_KEYING];
      new_cfg.clock_output_on      = word[BIT_CLK_ON];
   end

   // ==========================================================
   // Mode sequencer
   always_comb
   begin
      next_st       = st;
      next_st.sck_q = serial_clock;
      if (load)
      begin
         next_st.cfg       = new_cfg;
         next_st.cfg_valid = 1'b1;
      end
      // Pin conditions, load and low_cnt drive transitions
      case (st.mode)
         SC_OFF:
         begin
            next_st.cfg_valid = 1'b0;
            next_st.low_cnt   = '0;
            if (enable_line)
               next_st.mode = SC_CONFIG;
            else if (shared_data_modulation_line)
               next_st.mode = SC_RESET_WAIT;
         end
         SC_CONFIG:
         begin
            if (!enable_line)
               next_st.mode = shared_data_modulation_line ? SC_RESET_WAIT : SC_OFF;
            else if (load)
               next_st.mode = new_cfg.clock_only ? SC_CLOCK_ONLY : SC_TRANSMIT;
         end
         SC_RESET_WAIT:
         begin
            // Data must stay high with enable low for the minimum time
            if (enable_line || !shared_data_modulation_line)
            begin
               next_st.mode    = enable_line ? SC_CONFIG : SC_OFF;
               next_st.low_cnt = '0;
            end
            else if (st.low_cnt >= RESET_MIN_CNT - 8'h01)
               next_st.mode = SC_RESET_REG;
            else
               next_st.low_cnt = st.low_cnt + 8'h01;
         end
         SC_RESET_REG:
         begin
            // Crystal kept alive; a new word comes in under enable
            next_st.low_cnt = '0;
            if (enable_line)
               next_st.mode = SC_CONFIG;
            else if (!shared_data_modulation_line)
               next_st.mode = SC_OFF;
         end
         SC_TRANSMIT,
         SC_CLOCK_ONLY:
         begin
            if (!enable_line)
               next_st.mode = shared_data_modulation_line ? SC_RESET_WAIT : SC_OFF;
         end
         default:
            next_st.mode = SC_OFF;
      endcase

      // Circuit activity per mode
      next_st.blocks = '0;
      case (next_st.mode)
         SC_OFF:
            next_st.blocks = '0;
         SC_CONFIG:
         begin
            next_st.blocks.crystal_oscillator = 1'b1;
            next_st.blocks.synthesizer        = next_st.cfg_valid;
            next_st.blocks.clock_output_driver = next_st.cfg.clock_output_on;
         end
         SC_RESET_WAIT,
         SC_RESET_REG:
         begin
            next_st.blocks.crystal_oscillator  = 1'b1;
            next_st.blocks.clock_output_driver = next_st.cfg.clock_output_on;
         end
         SC_CLOCK_ONLY:
         begin
            next_st.blocks.crystal_oscillator  = 1'b1;
            next_st.blocks.clock_output_driver = next_st.cfg.clock_output_on;
         end
         SC_TRANSMIT:
         begin
            next_st.blocks.crystal_oscillator  = 1'b1;
            next_st.blocks.synthesizer         = 1'b1;
            next_st.blocks.clock_output_driver = next_st.cfg.clock_output_on;
            // Data line is now the modulation input
            if (next_st.cfg.keying_type_select)
               next_st.blocks.power_amplifier = shared_data_modulation_line;
            else
            begin
               next_st.blocks.power_amplifier = 1'b1;
               next_st.blocks.fsk_upper       = shared_data_modulation_line;
            end
         end
         default:
            next_st.blocks = '0;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st      <= '0;
         st.mode <= SC_OFF;
         st.cfg  <= CFG_RESET;
      end
      else
         st <= next_st;
   end

   // ==========================================================
   // Outputs
   assign active_cfg           = st.cfg;
   assign blocks               = st.blocks;
   assign mode                 = st.mode;
   assign clock_divide_by_four = st.cfg.clock_divider_select;

endmodule

// >>> hw/sc_pkg.sv
// Package for the serial configuration loader and mode sequencer.
// Assumes a single 10 MHz core clock and synchronous pin inputs.
package sc_pkg;

   // ==========================================================
   // Word layout
   localparam int CFG_WIDTH       = 32;
   localparam int BIT_CLK_ONLY    = 31;
   localparam int BIT_BAND        = 30;
   localparam int STEP_MSB        = 29;
   localparam int STEP_LSB        = 15;
   localparam int DEV_MSB         = 14;
   localparam int DEV_LSB         = 7;
   localparam int BIT_DIV         = 6;
   localparam int PA_MSB          = 5;
   localparam int PA_LSB          = 2;
   localparam int BIT_KEYING      = 1;
   localparam int BIT_CLK_ON      = 0;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS    = 100;
   localparam int RESET_MIN_US     = 10;
   localparam int RESET_MIN_CYCLES =
      (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W            = 8;
   localparam logic [CNT_W-1:0] RESET_MIN_CNT = CNT_W'(RESET_MIN_CYCLES);

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      SC_OFF,
      SC_CONFIG,
      SC_RESET_WAIT,
      SC_RESET_REG,
      SC_TRANSMIT,
      SC_CLOCK_ONLY
   } sc_mode_t;

   typedef struct packed {
      logic        clock_only;
      logic        vco_band_select;
      logic [14:0] carrier_step_word;
      logic [7:0]  fsk_deviation_word;
      logic        clock_divider_select;
      logic [3:0]  pa_level_code;
      logic        keying_type_select;
      logic        clock_output_on;
   } sc_cfg_t;

   typedef struct packed {
      logic crystal_oscillator;
      logic synthesizer;
      logic clock_output_driver;
      logic power_amplifier;
      logic fsk_upper;
   } sc_blocks_t;

endpackage

// >>> hw/sc_shift.sv
// Serial shift register with bit counter for the configuration word.
// Assumes edge strobes are one-cycle pulses made from the serial clock pin.
module sc_shift
   import sc_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   // Control
   input  wire logic                 restart,
   input  wire logic                 rise,
   input  wire logic                 fall,
   input  wire logic                 data_in,
   // Result
   output logic                      load,
   output logic [CFG_WIDTH-1:0]      word,
   output logic                      done
);

   typedef struct packed {
      logic [CFG_WIDTH-1:0] sr;
      logic [5:0]           count;
      logic                 full;
      logic                 done;
   } sc_shift_state_t;

   sc_shift_state_t st;
   sc_shift_state_t next_st;

   always_comb
   begin
      next_st = st;
      if (restart)
      begin
         next_st.count = 6'h00;
         next_st.full  = 1'b0;
         next_st.done  = 1'b0;
      end
      else if (!st.done)
      begin
         if (rise && !st.full)
         begin
            next_st.sr    = {st.sr[CFG_WIDTH-2:0], data_in};
            next_st.count = st.count + 6'h01;
            if (st.count == 6'(CFG_WIDTH - 1))
               next_st.full = 1'b1;
         end
         else if (fall && st.full)
            next_st.done = 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign load = !st.done && next_st.done && !restart;
   assign word = st.sr;
   assign done = st.done;

endmodule

// >>> test/sc_top_assertions.sv
// Checker for the serial configuration loader, watching top-level ports only.
// Assumes one core_clk domain and sys_rst synchronous, active high.
module sc_top_assertions
   import sc_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Host pins
   input  wire logic enable_line,
   input  wire logic shared_data_modulation_line,
   input  wire logic serial_clock,
   // Design outputs
   input  sc_cfg_t   active_cfg,
   input  sc_blocks_t blocks,
   input  sc_mode_t  mode,
   input  wire logic clock_divide_by_four
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Helper: cycles the pins have asked for register reset, saturating
   logic [CNT_W-1:0] hold_cnt;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || enable_line || !shared_data_modulation_line)
         hold_cnt <= '0;
      else if (hold_cnt != '1)
         hold_cnt <= hold_cnt + CNT_W'(1);
   end
   // ==========================================================
   // Assertions
   AST_OFF_STOPS: assert property (mode == SC_OFF |-> !blocks.crystal_oscillator && !blocks.synthesizer)
      else $error("off mode left oscillator or synthesizer running");
   AST_REG_RESET: assert property (mode == SC_RESET_REG |-> blocks.crystal_oscillator
      && !blocks.synthesizer && !blocks.power_amplifier) else $error("register reset blocks wrong");
   AST_CLK_GATE: assert property (!active_cfg.clock_output_on |-> !blocks.clock_output_driver)
      else $error("clock driver on while clock-on bit clear");
   AST_DIVIDER: assert property ($stable(active_cfg) |->
      clock_divide_by_four == active_cfg.clock_divider_select) else $error("divider select mismatch");
   AST_LOAD_MODE: assert property ($changed(active_cfg) |->
      mode == (active_cfg.clock_only ? SC_CLOCK_ONLY : SC_TRANSMIT)) else $error("mode after load wrong");
   AST_LOAD_ONLY_CONFIG: assert property ($changed(active_cfg) |-> $past(mode) == SC_CONFIG)
      else $error("configuration changed outside loading");
   AST_CLOCK_ONLY: assert property (mode == SC_CLOCK_ONLY |->
      !blocks.synthesizer && !blocks.power_amplifier) else $error("clock-only mode blocks wrong");
   AST_TX_BLOCKS: assert property (mode == SC_TRANSMIT |->
      blocks.crystal_oscillator && blocks.synthesizer) else $error("transmit blocks wrong");
   AST_ASK: assert property (mode == SC_TRANSMIT && $past(mode) == SC_TRANSMIT
      && active_cfg.keying_type_select |-> blocks.power_amplifier == $past(shared_data_modulation_line))
      else $error("amplitude keying does not follow data");
   AST_FSK: assert property (mode == SC_TRANSMIT && $past(mode) == SC_TRANSMIT
      && !active_cfg.keying_type_select |-> blocks.power_amplifier
      && blocks.fsk_upper == $past(shared_data_modulation_line)) else $error("frequency keying wrong");
   AST_RESET_MIN: assert property ($rose(mode == SC_RESET_REG) |-> $past(mode == SC_RESET_WAIT, 100))
      else $error("register reset entered too early");
   AST_RESET_HOLD: assert property ($rose(mode == SC_RESET_REG) |->
      hold_cnt >= RESET_MIN_CNT) else $error("register reset entered before the hold time");
   // ==========================================================
   // Covers
   COV_TX: cover property ($rose(mode == SC_TRANSMIT));
   COV_CLK_ONLY: cover property ($rose(mode == SC_CLOCK_ONLY));
   COV_REG_RESET: cover property ($rose(mode == SC_RESET_REG));
endmodule

// >>> test/sc_host_model.sv
// Host controller model driving enable, shared data and serial clock.
// Assumes pins change on falling core_clk edges; serial clock idles low.
module sc_host_model
(
   // Clock
   input  wire logic core_clk,
   // Host pins
   output logic      enable_line,
   output logic      shared_data_modulation_line,
   output logic      serial_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      enable_line = 1'b0;
      shared_data_modulation_line = 1'b0;
      serial_clock = 1'b0;
   end
   // Enable low with data low is off, with data high register reset
   task automatic pins(input logic en, input logic d);
      @(negedge core_clk);
      enable_line = en;
      shared_data_modulation_line = d;
   endtask
   // Bits 31 downward; a short count makes a deliberately partial word
   task automatic send(input logic [31:0] w, input int n);
      for (int i = 31; i > 31 - n; i--)
      begin
         @(negedge core_clk);
         shared_data_modulation_line = w[i];
         @(negedge core_clk);
         serial_clock = 1'b1;
         repeat (2) @(negedge core_clk);
         serial_clock = 1'b0;
         @(negedge core_clk);
      end
   endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the configuration loader and mode sequencer.
// Assumes the host model and checker files compile before this one.
module testbench
   import sc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic sys_rst  = 1'b1;
   logic en, sd, sck, div4;
   sc_cfg_t    cfg;
   sc_blocks_t blk;
   sc_mode_t   mode;
   int failures = 0;
   int total_checks = 0;
   localparam logic [31:0] W1 = {1'b0, 1'b1, 15'h1234, 8'h5a, 1'b1, 4'hf, 1'b1, 1'b1};
   localparam logic [31:0] W2 = {1'b1, 1'b0, 15'h7fff, 8'h00, 1'b0, 4'h0, 1'b0, 1'b0};
   localparam logic [31:0] W3 = {1'b0, 1'b0, 15'h0001, 8'hff, 1'b0, 4'h3, 1'b0, 1'b1};
   always #50 core_clk = ~core_clk;
   sc_host_model i_host (.core_clk(core_clk), .enable_line(en),
      .shared_data_modulation_line(sd), .serial_clock(sck));
   sc_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .enable_line(en),
      .shared_data_modulation_line(sd), .serial_clock(sck), .active_cfg(cfg),
      .blocks(blk), .mode(mode), .clock_divide_by_four(div4));
   // ==========================================================
   // Checking and verdict
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // ==========================================================
   // Tests
   initial
   begin
      repeat (20) @(negedge core_clk);
      sys_rst = 1'b0;
      i_host.pins(1'b1, 1'b0);
      settle(2);
      check("mode config", 32'(mode), 32'(SC_CONFIG));
      check("crystal start", 32'(blk.crystal_oscillator), 32'h1);
      i_host.send(W1, 32);
      settle(4);
      check("cfg w1", 32'(cfg), W1);
      check("mode tx", 32'(mode), 32'(SC_TRANSMIT));
      check("div four", 32'(div4), 32'h1);
      check("tx blocks", 32'({blk.crystal_oscillator, blk.synthesizer,
         blk.clock_output_driver}), 32'h7);
      i_host.pins(1'b1, 1'b1);
      settle(3);
      check("ask high", 32'(blk.power_amplifier), 32'h1);
      i_host.pins(1'b1, 1'b0);
      settle(3);
      check("ask low", 32'(blk.power_amplifier), 32'h0);
      // Edges after a load must be ignored
      i_host.send(W2, 32);
      settle(4);
      check("cfg kept", 32'(cfg), W1);
      i_host.pins(1'b0, 1'b0);
      settle(3);
      check("mode off", 32'(mode), 32'(SC_OFF));
      check("off blocks", 32'(blk), 32'h0);
      i_host.pins(1'b1, 1'b0);
      i_host.send(W2, 32);
      settle(4);
      check("cfg w2", 32'(cfg), W2);
      check("mode clk only", 32'(mode), 32'(SC_CLOCK_ONLY));
      check("clock_output_driver off", 32'(blk.clock_output_driver), 32'h0);
      check("div eight", 32'(div4), 32'h0);
      // A word one bit short never applies
      i_host.pins(1'b0, 1'b0);
      i_host.pins(1'b1, 1'b0);
      i_host.send(W3, 31);
      settle(4);
      check("partial", 32'(cfg), W2);
      check("partial mode", 32'(mode), 32'(SC_CONFIG));
      i_host.pins(1'b0, 1'b1);
      settle(110);
      check("mode reg reset", 32'(mode), 32'(SC_RESET_REG));
      check("reg reset blocks", 32'({blk.crystal_oscillator, blk.synthesizer,
         blk.power_amplifier}), 32'h4);
      i_host.pins(1'b1, 1'b1);
      settle(100);
      check("mode reconfig", 32'(mode), 32'(SC_CONFIG));
      i_host.send(W3, 32);
      settle(4);
      check("cfg w3", 32'(cfg), W3);
      i_host.pins(1'b1, 1'b1);
      settle(3);
      check("fsk upper", 32'({blk.power_amplifier, blk.fsk_upper}), 32'h3);
      i_host.pins(1'b1, 1'b0);
      settle(3);
      check("fsk lower", 32'({blk.power_amplifier, blk.fsk_upper}), 32'h2);
      i_host.pins(1'b0, 1'b0);
      settle(3);
      check("back off", 32'(mode), 32'(SC_OFF));
      // Too short a hold never reaches register reset
      i_host.pins(1'b0, 1'b1);
      settle(50);
      check("reset wait", 32'(mode), 32'(SC_RESET_WAIT));
      i_host.pins(1'b0, 1'b0);
      settle(3);
      check("wait abort", 32'(mode), 32'(SC_OFF));
      check("wait abort blocks", 32'(blk), 32'h0);
      give_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      failures++;
      give_verdict();
   end
endmodule
bind sc_top sc_top_assertions i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .enable_line(enable_line), .shared_data_modulation_line(shared_data_modulation_line),
   .serial_clock(serial_clock), .active_cfg(active_cfg), .blocks(blocks), .mode(mode),
   .clock_divide_by_four(clock_divide_by_four));
